// ==== shared/lcs_pkg.sv ====
package lcs_pkg;

	// Clock rate
	localparam int CLK_MHZ = 200;

	// Timer prescaler: one tick per second
	localparam int TICK_TIME_MS = 1000;
	localparam int TICK_CYCLES_DEF = TICK_TIME_MS * 1000 * CLK_MHZ;
	localparam int TICK_W = 28;

	// Supply glitch filter time
	localparam int GLITCH_TIME_US = 10;
	localparam int GLITCH_CYCLES = GLITCH_TIME_US * CLK_MHZ;
	localparam int GLITCH_W = 12;

	// Charge timer settings
	localparam int SEC_W = 15;
	localparam logic [SEC_W-1:0] SEC_PER_HOUR = 15'h0e10;
	localparam logic [2:0] INT_TIMER_HOURS = 3'h3;
	localparam int PRECHARGE_SHIFT = 2;

	// Reset values
	localparam logic [2:0] SYNC_RST = 3'h0;
	localparam logic [GLITCH_W-1:0] GLITCH_RST = 12'h000;
	localparam logic [TICK_W-1:0] TICK_RST = 28'h0000000;
	localparam logic [SEC_W-1:0] SEC_RST = 15'h0000;

	// Constant-voltage target selection
	typedef enum logic [1:0] {
		LCS_CV_4V1,
		LCS_CV_4V2,
		LCS_CV_ADJ
	} lcs_cv_t;

	// Charge sequencer states
	typedef enum logic [2:0] {
		LCS_OFF,
		LCS_LDO,
		LCS_PRECHARGE,
		LCS_FAST,
		LCS_CV,
		LCS_TERM_HOLD,
		LCS_MONITOR,
		LCS_PRE_FAULT
	} lcs_state_t;

	// Raw pin and comparator levels, synchronised as a bundle
	typedef struct packed {
		logic vcc_above_uvlo;
		logic thermistor_disable;
		logic thermistor_force_enable;
		logic thermistor_hot;
		logic thermistor_cold;
		logic battery_present_bar;
		logic vprog_high;
		logic vprog_resistor;
		logic timer_tied_supply;
		logic timer_grounded;
		logic [2:0] timer_program_hours;
		logic vout_above_precondition;
		logic vout_at_cv;
		logic iout_below_termination;
		logic vout_below_recharge;
	} lcs_pins_t;

	// Seconds for a timer setting in hours
	function automatic logic [SEC_W-1:0] lcs_hours_to_sec(input logic [2:0] hours);
		logic [SEC_W+2:0] prod;
		prod = {15'h0000, hours} * {3'h0, SEC_PER_HOUR};
		return prod[SEC_W-1:0];
	endfunction : lcs_hours_to_sec

endpackage : lcs_pkg

// ==== shared/lcs_timer_if.sv ====
`timescale 1ns/1ps
interface lcs_timer_if;
	import lcs_pkg::*;
	logic run;
	logic clear;
	logic [2:0] hours;
	logic expired;
	logic pre_expired;
	logic blink;

	modport ctrl (output run, output clear, output hours, input expired, input pre_expired, input blink);
	modport timer (input run, input clear, input hours, output expired, output pre_expired, output blink);
endinterface : lcs_timer_if

// ==== src/lcs_charge_timer.sv ====
`timescale 1ns/1ps
module lcs_charge_timer
	import lcs_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Sequencer side
	lcs_timer_if.timer tmr
);

	logic [TICK_W-1:0] presc_r;
	logic tick_r;
	logic [SEC_W-1:0] elapsed_r;
	logic [2:0] blink_cnt_r;
	logic blink_r;
	logic [SEC_W-1:0] total_sec;

	always_ff @(posedge clock_i)
	begin
		if (rst_i || presc_r == TICK_W'(TICK_CYCLES - 1))
		begin
			presc_r <= TICK_RST;
		end
		else
		begin
			presc_r <= presc_r + 28'h0000001;
		end
		tick_r <= !rst_i && presc_r == TICK_W'(TICK_CYCLES - 1);
	end

	// counts only while running, so a pause keeps the count
	always_ff @(posedge clock_i)
	begin
		if (rst_i || tmr.clear)
		begin
			elapsed_r <= SEC_RST;
		end
		else if (tmr.run && tick_r && elapsed_r != {SEC_W{1'b1}})
		begin
			elapsed_r <= elapsed_r + 15'h0001;
		end
	end

	// blink half-period grows with the timer setting
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			blink_cnt_r <= SYNC_RST;
			blink_r <= 1'b0;
		end
		else if (tick_r)
		begin
			if (blink_cnt_r + 3'h1 >= tmr.hours)
			begin
				blink_cnt_r <= SYNC_RST;
				blink_r <= !blink_r;
			end
			else
			begin
				blink_cnt_r <= blink_cnt_r + 3'h1;
			end
		end
	end

	assign total_sec = lcs_hours_to_sec(tmr.hours);
	assign tmr.expired = elapsed_r >= total_sec;
	// pre-charge limit is a quarter of the total
	assign tmr.pre_expired = elapsed_r >= (total_sec >> PRECHARGE_SHIFT);
	assign tmr.blink = blink_r;

endmodule : lcs_charge_timer

// ==== src/lcs_charge_sequencer.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Voltage-program pin picks 4.1V, 4.2V or adjust
// - Enable pin high enables, low disables, mid monitors
// - Present-bar high gives LDO, no pre-charge/timer
// - Charging indicator low above termination current
// - Charger-present indicator low above supply threshold
// - Timer pin selects internal, programmed or disabled
// - Filtered supply above threshold starts charge cycle
// - Pre-charge below 2.8V, fast-charge above
// - Reaching final voltage switches to constant voltage
// - Timed termination holds CV until expiry
// - Monitor restarts charge on recharge droop
// - Untimed termination turns output off immediately
// - Pre-charge over quarter time faults, blinks
// - Fault cleared by disable, supply cycle, 2.8V
// - Recharge clears and restarts the charge timer
// - Temperature fault suspends, pauses timer, blinks
// - Disable turns off, resets timer, releases indicator
module lcs_charge_sequencer
	import lcs_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Supply and enable/thermistor comparators
	input wire logic vcc_above_uvlo_i,
	input wire logic thermistor_disable_i,
	input wire logic thermistor_force_enable_i,
	input wire logic thermistor_hot_i,
	input wire logic thermistor_cold_i,
	// Mode selection pins
	input wire logic battery_present_bar_i,
	input wire logic vprog_high_i,
	input wire logic vprog_resistor_i,
	input wire logic timer_tied_supply_i,
	input wire logic timer_grounded_i,
	input wire logic [2:0] timer_program_hours_i,
	// Output voltage and current comparators
	input wire logic vout_above_precondition_i,
	input wire logic vout_at_cv_i,
	input wire logic iout_below_termination_i,
	input wire logic vout_below_recharge_i,
	// Open-drain charging indicator
	input wire logic charging_indicator_n_i,
	output logic charging_indicator_n_o,
	output logic charging_indicator_n_oe_n_o,
	// Open-drain charger-present indicator
	input wire logic charger_present_indicator_n_i,
	output logic charger_present_indicator_n_o,
	output logic charger_present_indicator_n_oe_n_o,
	// Analog regulator controls
	output logic output_on_o,
	output logic precharge_mode_o,
	output logic fast_mode_o,
	output logic cv_mode_o,
	output lcs_cv_t constant_voltage_target_o,
	output logic precharge_fault_o
);

	lcs_pins_t raw;
	lcs_pins_t sync1_r;
	lcs_pins_t sync2_r;
	logic [GLITCH_W-1:0] glitch_cnt_r;
	logic supply_ok_r;
	lcs_state_t state_r;
	lcs_state_t state_nxt;
	logic timer_clear_r;
	logic timer_en;
	logic temp_fault;
	logic charging;
	logic blink_state;
	lcs_timer_if tif ();

	// The indicator pin levels are not needed by the sequencer
	logic unused_pins;
	assign unused_pins = charging_indicator_n_i ^ charger_present_indicator_n_i;

	assign raw = '{vcc_above_uvlo: vcc_above_uvlo_i, thermistor_disable: thermistor_disable_i,
		thermistor_force_enable: thermistor_force_enable_i, thermistor_hot: thermistor_hot_i,
		thermistor_cold: thermistor_cold_i, battery_present_bar: battery_present_bar_i,
		vprog_high: vprog_high_i, vprog_resistor: vprog_resistor_i,
		timer_tied_supply: timer_tied_supply_i, timer_grounded: timer_grounded_i,
		timer_program_hours: timer_program_hours_i, vout_above_precondition: vout_above_precondition_i,
		vout_at_cv: vout_at_cv_i, iout_below_termination: iout_below_termination_i,
		vout_below_recharge: vout_below_recharge_i};

	// Two-stage synchroniser for every pin level
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= raw;
			sync2_r <= sync1_r;
		end
	end

	// supply must stay high for the filter time; a drop acts at once
	always_ff @(posedge clock_i)
	begin
		if (rst_i || !sync2_r.vcc_above_uvlo)
		begin
			glitch_cnt_r <= GLITCH_RST;
			supply_ok_r <= 1'b0;
		end
		else if (glitch_cnt_r == GLITCH_W'(GLITCH_CYCLES - 1))
		begin
			supply_ok_r <= 1'b1;
		end
		else
		begin
			glitch_cnt_r <= glitch_cnt_r + 12'h001;
		end
	end

	// mid-range levels outside the safe window are a temperature fault
	assign temp_fault = !sync2_r.thermistor_disable && !sync2_r.thermistor_force_enable &&
		(sync2_r.thermistor_hot || sync2_r.thermistor_cold);
	// timer is off in LDO mode; grounded pin disables it
	assign timer_en = !sync2_r.timer_grounded && !sync2_r.battery_present_bar;
	assign charging = state_r == LCS_PRECHARGE || state_r == LCS_FAST || state_r == LCS_CV;

	// Timer hookup
	assign tif.clear = timer_clear_r;
	// timer pauses while the temperature is out of range
	assign tif.run = timer_en && !temp_fault && (charging || state_r == LCS_TERM_HOLD);
	// internal rate when tied to supply or disabled
	assign tif.hours = (sync2_r.timer_tied_supply || sync2_r.timer_grounded) ? INT_TIMER_HOURS
		: sync2_r.timer_program_hours;

	lcs_charge_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tmr(tif.timer)
	);

	// Next state of the charge sequence
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			LCS_OFF, LCS_LDO, LCS_MONITOR:
			begin
				if (state_r == LCS_LDO && !sync2_r.battery_present_bar)
				begin
					state_nxt = LCS_OFF;
				end
				// LDO mode bypasses the charge sequence
				else if (state_r == LCS_OFF && sync2_r.battery_present_bar)
				begin
					state_nxt = LCS_LDO;
				end
				else if (state_r == LCS_OFF || (state_r == LCS_MONITOR && sync2_r.vout_below_recharge))
				begin
					state_nxt = sync2_r.vout_above_precondition ? LCS_FAST : LCS_PRECHARGE;
				end
			end
			LCS_PRECHARGE:
			begin
				if (sync2_r.vout_above_precondition)
				begin
					state_nxt = LCS_FAST;
				end
				// pre-charge too long; a count still being cleared is stale
				else if (timer_en && tif.pre_expired && !timer_clear_r)
				begin
					state_nxt = LCS_PRE_FAULT;
				end
			end
			LCS_PRE_FAULT:
			begin
				// fault clears when output rises above 2.8V
				if (sync2_r.vout_above_precondition)
				begin
					state_nxt = LCS_FAST;
				end
			end
			LCS_FAST:
			begin
				// move to constant voltage at target
				if (sync2_r.vout_at_cv)
				begin
					state_nxt = LCS_CV;
				end
			end
			LCS_CV:
			begin
				// timed hold; untimed stop at once
				if (sync2_r.iout_below_termination)
				begin
					state_nxt = timer_en ? LCS_TERM_HOLD : LCS_MONITOR;
				end
			end
			LCS_TERM_HOLD:
			begin
				// a timer switched off while holding ends the hold at once
				state_nxt = timer_en ? LCS_TERM_HOLD : LCS_MONITOR;
			end
		endcase
		// expiry ends any timed charge; the old count is ignored while a restart clears it
		if (timer_en && tif.expired && !timer_clear_r && (charging || state_r == LCS_TERM_HOLD) &&
			state_nxt != LCS_PRE_FAULT)
		begin
			state_nxt = LCS_MONITOR;
		end
		// Leaving charge mode for LDO at any time
		if (state_r != LCS_OFF && state_r != LCS_LDO && sync2_r.battery_present_bar)
		begin
			state_nxt = LCS_LDO;
		end
	end

	// lockout and disable hold the state in LCS_OFF; disable stops charging
	always_ff @(posedge clock_i)
	begin
		if (rst_i || !supply_ok_r || sync2_r.thermistor_disable)
		begin
			state_r <= LCS_OFF;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// restart clears the timer; disable and lockout clear it too
	always_ff @(posedge clock_i)
	begin
		timer_clear_r <= rst_i || !supply_ok_r || sync2_r.thermistor_disable || state_r == LCS_OFF ||
			(state_r == LCS_MONITOR && state_nxt != LCS_MONITOR);
	end

	// Blink for temperature or pre-charge fault
	assign blink_state = (temp_fault && (charging || state_r == LCS_TERM_HOLD)) || state_r == LCS_PRE_FAULT;

	// Registered analog controls
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			output_on_o <= 1'b0;
			precharge_mode_o <= 1'b0;
			fast_mode_o <= 1'b0;
			cv_mode_o <= 1'b0;
			precharge_fault_o <= 1'b0;
			constant_voltage_target_o <= LCS_CV_4V1;
		end
		else
		begin
			// output off during a temperature fault
			output_on_o <= !temp_fault && (charging || state_r == LCS_TERM_HOLD || state_r == LCS_LDO);
			precharge_mode_o <= state_r == LCS_PRECHARGE;
			fast_mode_o <= state_r == LCS_FAST;
			cv_mode_o <= state_r == LCS_CV || state_r == LCS_TERM_HOLD || state_r == LCS_LDO;
			precharge_fault_o <= state_r == LCS_PRE_FAULT;
			constant_voltage_target_o <= sync2_r.vprog_resistor ? LCS_CV_ADJ :
				(sync2_r.vprog_high ? LCS_CV_4V2 : LCS_CV_4V1);
		end
	end

	// Open-drain indicators: data always low, enable low means driven
	always_ff @(posedge clock_i)
	begin
		charging_indicator_n_o <= 1'b0;
		charger_present_indicator_n_o <= 1'b0;
		if (rst_i)
		begin
			charging_indicator_n_oe_n_o <= 1'b1;
			charger_present_indicator_n_oe_n_o <= 1'b1;
		end
		else
		begin
			// present while the filtered supply is good
			charger_present_indicator_n_oe_n_o <= !supply_ok_r;
			if (blink_state)
			begin
				charging_indicator_n_oe_n_o <= !tif.blink;
			end
			else
			begin
				// low while current above termination; released when off
				charging_indicator_n_oe_n_o <= !((charging || state_r == LCS_LDO) && !sync2_r.iout_below_termination);
			end
		end
	end

endmodule : lcs_charge_sequencer

// ==== verification/lcs_charge_sequencer_asserts.sv ====
`timescale 1ns/1ps
module lcs_seq_asserts
	import lcs_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Watched inputs
	input wire logic vcc_above_uvlo_i,
	input wire logic thermistor_disable_i,
	input wire logic battery_present_bar_i,
	input wire logic vprog_resistor_i,
	// Watched outputs
	input wire logic charging_indicator_n_oe_n_o,
	input wire logic charger_present_indicator_n_oe_n_o,
	input wire logic output_on_o,
	input wire logic precharge_mode_o,
	input wire logic fast_mode_o,
	input wire logic cv_mode_o,
	input wire lcs_cv_t constant_voltage_target_o,
	input wire logic precharge_fault_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	rst_off_a: assert property (disable iff (1'b0) rst_i |=> !output_on_o
		&& charging_indicator_n_oe_n_o && !precharge_fault_o) else $error("outputs not cleared by reset");
	mode_excl_a: assert property ($onehot0({precharge_mode_o, fast_mode_o, cv_mode_o}))
		else $error("two regulation modes at once");
	fault_off_a: assert property (precharge_fault_o |-> !output_on_o)
		else $error("output on during fault");
	fault_src_a: assert property ($rose(precharge_fault_o) |-> $past(precharge_mode_o))
		else $error("fault raised outside precharge");
	uvlo_off_a: assert property (!vcc_above_uvlo_i [*6] |-> !output_on_o
		&& charger_present_indicator_n_oe_n_o) else $error("active under lockout");
	disable_off_a: assert property (thermistor_disable_i [*6] |-> !output_on_o
		&& charging_indicator_n_oe_n_o) else $error("active while disabled");
	target_adj_a: assert property (vprog_resistor_i [*6] |-> constant_voltage_target_o == LCS_CV_ADJ)
		else $error("adjust target not chosen");
	ldo_nopre_a: assert property (battery_present_bar_i [*6] |-> !precharge_mode_o)
		else $error("precharge in LDO mode");
	supply_start_a: assert property ($rose(output_on_o) |-> $past(vcc_above_uvlo_i, 8))
		else $error("start without filtered supply");
endmodule : lcs_seq_asserts

bind lcs_charge_sequencer lcs_seq_asserts u_chk (.clock_i, .rst_i, .vcc_above_uvlo_i, .thermistor_disable_i,
	.battery_present_bar_i, .vprog_resistor_i, .charging_indicator_n_oe_n_o, .charger_present_indicator_n_oe_n_o,
	.output_on_o, .precharge_mode_o, .fast_mode_o, .cv_mode_o, .constant_voltage_target_o, .precharge_fault_o);

// ==== verification/lcs_battery_model.sv ====
`timescale 1ns/1ps
module lcs_battery_model
(
	// Clock
	input wire logic clock_i,
	// Charger controls
	input wire logic on_i,
	input wire logic pre_i,
	input wire logic fast_i,
	input wire logic cv_i,
	input wire logic load_i,
	// Open-drain indicators
	input wire logic chg_i,
	input wire logic chg_oe_n_i,
	input wire logic cp_i,
	input wire logic cp_oe_n_i,
	output logic chg_pin_o,
	output logic cp_pin_o,
	// Comparator levels
	output logic above_pre_o,
	output logic at_cv_o,
	output logic below_term_o,
	output logic below_rech_o
);
	int mv = 2000;
	int ma = 100;
	// fast rate fixed, analog input tied high; load drains the cell
	always @(posedge clock_i)
	begin
		mv <= mv + ((on_i && mv < 4200) ? (fast_i ? 2 : 32'(pre_i)) : 0) - 32'(load_i && mv > 0);
		ma <= (cv_i && on_i) ? (ma > 0 ? ma - 1 : 0) : 100;
	end
	// Thresholds seen by the charger
	assign above_pre_o = mv > 2800;
	assign at_cv_o = mv >= 4200;
	assign below_term_o = !on_i || ma == 0;
	assign below_rech_o = mv < 4100;
	// Pull-ups: a released pin reads high
	assign chg_pin_o = chg_oe_n_i ? 1'b1 : chg_i;
	assign cp_pin_o = cp_oe_n_i ? 1'b1 : cp_i;
endmodule : lcs_battery_model

// ==== verification/lcs_charge_sequencer_test.sv ====
`timescale 1ns/1ps
module lcs_charge_sequencer_test
	import lcs_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic vcc = 1'b0;
	logic dis = 1'b0;
	logic fen = 1'b1;
	logic hot = 1'b0;
	logic cold = 1'b0;
	logic bpb = 1'b0;
	logic vph = 1'b1;
	logic vpr = 1'b0;
	logic tts = 1'b0;
	logic tgd = 1'b1;
	logic load = 1'b0;
	logic [2:0] hrs = 3'h3;
	localparam int TCK = 2;
	logic chg, chg_oe, cp, cp_oe, on, pre, fast, cv, flt;
	logic apre, atcv, bterm, brech, chgp, cpp;
	lcs_cv_t tgt;
	int err_count = 0;
	int compares = 0;

	// Short prescaler keeps the 3 h timer near 21600 cycles
	lcs_charge_sequencer #(.TICK_CYCLES(TCK)) uut (.clock_i(clk), .rst_i(rst), .vcc_above_uvlo_i(vcc),
		.thermistor_disable_i(dis), .thermistor_force_enable_i(fen), .thermistor_hot_i(hot),
		.thermistor_cold_i(cold), .battery_present_bar_i(bpb), .vprog_high_i(vph), .vprog_resistor_i(vpr),
		.timer_tied_supply_i(tts), .timer_grounded_i(tgd), .timer_program_hours_i(hrs),
		.vout_above_precondition_i(apre), .vout_at_cv_i(atcv), .iout_below_termination_i(bterm),
		.vout_below_recharge_i(brech), .charging_indicator_n_i(chgp), .charging_indicator_n_o(chg),
		.charging_indicator_n_oe_n_o(chg_oe), .charger_present_indicator_n_i(cpp),
		.charger_present_indicator_n_o(cp), .charger_present_indicator_n_oe_n_o(cp_oe), .output_on_o(on),
		.precharge_mode_o(pre), .fast_mode_o(fast), .cv_mode_o(cv), .constant_voltage_target_o(tgt),
		.precharge_fault_o(flt));
	lcs_battery_model bat (.clock_i(clk), .on_i(on), .pre_i(pre), .fast_i(fast), .cv_i(cv), .load_i(load),
		.chg_i(chg), .chg_oe_n_i(chg_oe), .cp_i(cp), .cp_oe_n_i(cp_oe), .chg_pin_o(chgp), .cp_pin_o(cpp),
		.above_pre_o(apre), .at_cv_o(atcv), .below_term_o(bterm), .below_rech_o(brech));

	// Clock at 200 MHz
	initial
	begin
		forever #2.5 clk = ~clk;
	end

	// Count a comparison, report a mismatch
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		compares++;
		if (e !== s)
		begin
			$display("BAD %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask : chk

	// Bounded wait for a level; a timeout ends the run
	task automatic wt(input string n, ref logic s, input logic v, input int lim);
		int i;
		i = 0;
		while (s !== v && i < lim)
		begin
			@(negedge clk);
			i++;
		end
		chk(n, v, s);
		if (s !== v)
			summarize();
	endtask : wt

	// Blink half-period in clock cycles is the hours setting counted in ticks
	task automatic blink(input string n, input int hours);
		logic a;
		int c;
		repeat (4) @(negedge clk);
		a = chg_oe;
		wt(n, chg_oe, !a, 20);
		a = chg_oe;
		c = 0;
		while (chg_oe === a && c < 40)
		begin
			@(negedge clk);
			c++;
		end
		chk(n, 8'(hours * TCK), 8'(c));
		if (chg_oe === a)
			summarize();
	endtask : blink

	// Reset, then let the filtered supply start a cycle
	task automatic power(input logic tie_supply, input logic tie_ground);
		tts = tie_supply;
		tgd = tie_ground;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		chk("rst_on", 0, on);
		chk("rst_chg_oe", 1, chg_oe);
		rst = 1'b0;
		vcc = 1'b1;
		repeat (1900) @(negedge clk);
		chk("early_on", 0, on);
		wt("on", on, 1, 300);
		chk("cp_oe", 0, cp_oe);
		chk("cp_pin", 0, cpp);
	endtask : power

	// Untimed charge through all phases, then recharge
	task automatic t_untimed;
		bat.mv = 2000;
		power(1'b0, 1'b1);
		wt("pre", pre, 1, 5);
		wt("chg_oe", chg_oe, 0, 5);
		chk("chg_pin", 0, chgp);
		fen = 1'b0;
		hot = 1'b1;
		blink("blink_off", INT_TIMER_HOURS);
		hot = 1'b0;
		fen = 1'b1;
		wt("fast", fast, 1, 1000);
		wt("cv", cv, 1, 1000);
		wt("on", on, 0, 200);
		wt("chg_oe", chg_oe, 1, 5);
		load = 1'b1;
		wt("on", on, 1, 300);
		load = 1'b0;
	endtask : t_untimed

	// Timed charge holds CV until expiry
	task automatic t_timed;
		bat.mv = 3000;
		power(1'b1, 1'b0);
		wt("cv", cv, 1, 1000);
		wt("chg_oe", chg_oe, 1, 200);
		chk("on", 1, on);
		wt("on", on, 0, 22000);
		load = 1'b1;
		wt("on", on, 1, 300);
		load = 1'b0;
		@(negedge clk);
		chk("on_hold", 1, on);
		repeat (200) @(negedge clk);
		chk("on", 1, on);
	endtask : t_timed

	// Programmed two-hour timer: earlier fault, faster blink, cleared by supply loss
	task automatic t_prog;
		hrs = 3'h2;
		bat.mv = 1000;
		load = 1'b1;
		power(1'b0, 1'b0);
		wt("flt", flt, 1, 3700);
		blink("blink_prog", 2);
		vcc = 1'b0;
		wt("flt", flt, 0, 10);
		chk("cp_oe", 1, cp_oe);
	endtask : t_prog

	// Stuck precharge faults; cleared by disable and by voltage
	task automatic t_fault;
		bat.mv = 1000;
		load = 1'b1;
		power(1'b1, 1'b0);
		wt("flt", flt, 1, 6000);
		chk("on", 0, on);
		blink("blink_int", INT_TIMER_HOURS);
		dis = 1'b1;
		fen = 1'b0;
		wt("flt", flt, 0, 10);
		wt("chg_oe", chg_oe, 1, 10);
		dis = 1'b0;
		fen = 1'b1;
		wt("flt", flt, 1, 6000);
		bat.mv = 3000;
		load = 1'b0;
		wt("fast", fast, 1, 10);
		chk("flt", 0, flt);
	endtask : t_fault

	// Hot then cold suspend and resume
	task automatic t_temp;
		for (int k = 0; k < 2; k++)
		begin
			fen = 1'b0;
			hot = (k == 0);
			cold = (k == 1);
			wt("on", on, 0, 10);
			blink("blink_temp", INT_TIMER_HOURS);
			hot = 1'b0;
			cold = 1'b0;
			fen = 1'b1;
			wt("on", on, 1, 10);
		end
	endtask : t_temp

	// LDO, voltage targets, disable, supply loss
	task automatic t_modes;
		bpb = 1'b1;
		wt("cv", cv, 1, 10);
		chk("pre", 0, pre);
		chk("on", 1, on);
		bpb = 1'b0;
		for (int k = 0; k < 3; k++)
		begin
			vph = (k == 1);
			vpr = (k == 2);
			repeat (8) @(negedge clk);
			chk("tgt", k == 2 ? LCS_CV_ADJ : k == 1 ? LCS_CV_4V2 : LCS_CV_4V1, tgt);
		end
		dis = 1'b1;
		fen = 1'b0;
		wt("on", on, 0, 10);
		dis = 1'b0;
		fen = 1'b1;
		wt("on", on, 1, 10);
		vcc = 1'b0;
		wt("cp_oe", cp_oe, 1, 10);
		wt("on", on, 0, 10);
	endtask : t_modes

	// Counts and verdict
	task automatic summarize;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	// Main sequence
	initial
	begin
		t_untimed();
		t_timed();
		t_prog();
		t_fault();
		t_temp();
		t_modes();
		summarize();
	end
endmodule : lcs_charge_sequencer_test
